/* dv/fan_model.sv */
/*
 fan partner: one fan on a duty output, spinning or at full speed.
 assumes duty codes change only on clk and fans are idle after reset.
*/
`timescale 1ns/100ps
module fan_model (
	input  wire logic       clk,
	input  wire logic       resetn,
	input  wire logic [7:0] duty,
	output logic            spinning_q,
	output logic            full_q
);
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			spinning_q <= 1'b0;
			full_q     <= 1'b0;
		end else begin
			spinning_q <= duty != 8'h00;
			full_q     <= duty == 8'hFF;
		end
	end
endmodule

/* dv/testbench.sv */
/*
 testbench for the fan limit register bank: wishbone tasks and sequences.
 assumes duties settle within eight cycles of a temperature change.
*/
`timescale 1ns/100ps
module testbench;
	import fan_limit_pkg::*;
	logic              clk = 1'b0;
	logic              resetn = 1'b0;
	logic [ADDR_W-1:0] adr = '0;
	logic [31:0]       wdat = '0;
	logic [3:0]        sel = 4'h0;
	logic              we = 1'b0;
	logic              cyc = 1'b0;
	logic              stb = 1'b0;
	logic [9:0]        t_r1 = 10'h140;
	logic [9:0]        t_loc = 10'h140;
	logic [9:0]        t_r2 = 10'h140;
	logic [31:0]       rdat;
	logic [31:0]       q;
	logic [7:0]        duty_0, duty_1, duty_2;
	logic              crit_n, xor_en, irq, ack;
	logic [2:0]        spin, full;
	logic [7:0]        rv [14] = '{8'h80, 8'h80, 8'h80, 8'h5A, 8'h5A,
		8'h5A, 8'h64, 8'h64, 8'h64, 8'h44, 8'h40, 8'h00, 8'h00, 8'h00};
	int                mismatches = 0;
	int                cmp_count = 0;

	always #2.5 clk = ~clk;

	fan_limit_regs dut (.clk(clk), .resetn(resetn), .wb_adr_i(adr),
		.wb_dat_i(wdat), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack),
		.temp_remote1(t_r1), .temp_local(t_loc), .temp_remote2(t_r2),
		.duty_0(duty_0), .duty_1(duty_1), .duty_2(duty_2),
		.critical_temp_signal_n(crit_n), .xor_test_enable(xor_en),
		.irq(irq));
	fan_model fan0 (.clk(clk), .resetn(resetn), .duty(duty_0),
		.spinning_q(spin[0]), .full_q(full[0]));
	fan_model fan1 (.clk(clk), .resetn(resetn), .duty(duty_1),
		.spinning_q(spin[1]), .full_q(full[1]));
	fan_model fan2 (.clk(clk), .resetn(resetn), .duty(duty_2),
		.spinning_q(spin[2]), .full_q(full[2]));

	task report_and_stop;
		$display("checks %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected %s exp %h got %h", nm, e, g);
		end
	endtask

	// hold request until ack is sampled high
	task xfer(input logic [7:0] idx, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		cyc  <= 1'b1;
		stb  <= 1'b1;
		adr  <= {idx, 2'b00};
		we   <= w;
		wdat <= d;
		sel  <= 4'hF;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (ack !== 1'b1) begin
			mismatches++;
			$display("unexpected ack exp 1 got %b", ack);
		end
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we  <= 1'b0;
	endtask

	task wr(input logic [7:0] idx, input logic [31:0] d);
		xfer(idx, 1'b1, d);
	endtask

	task rd(input logic [7:0] idx, input logic [7:0] e);
		xfer(idx, 1'b0, 32'h0);
		chk("register", {24'h0, e}, q);
	endtask

	// temperatures in whole degrees, driven as quarter degrees
	task temps(input int a, input int b);
		t_r1  <= 10'(a * 4);
		t_loc <= 10'(b * 4);
		repeat (8) @(posedge clk);
	endtask

	initial begin
		#200000;
		mismatches++;
		report_and_stop();
	end

	initial begin
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		for (int i = 0; i < 14; i++)
			rd(8'h64 + 8'(i), rv[i]);
		rd(8'h90, 8'h00);
		// only bit 0 is ever written here
		wr(IDX_XOR_TEST, 32'h1);
		@(posedge clk);
		chk("xor_en", 1'b1, xor_en);
		wr(IDX_XOR_TEST, 32'h0);
		@(posedge clk);
		chk("xor_en", 1'b0, xor_en);
		wr(8'h65, 32'h40);
		wr(IDX_CRIT_LOC, 32'h80);
		// auto, pin enabled, zero below start, widest span
		wr(IDX_CONTROL, 32'h0F06);
		wr(8'h65, 32'h00);
		rd(8'h65, 8'h40);
		// default hysteresis of four degrees kept
		temps(80, 80);
		chk("duty_0", 8'h00, duty_0);
		temps(91, 80);
		chk("duty_0", 8'h80, duty_0);
		chk("spin", 3'b001, spin);
		temps(88, 80);
		chk("duty_0", 8'h80, duty_0);
		temps(85, 130);
		chk("duty_0", 8'h00, duty_0);
		chk("duty_1", 8'h40, duty_1);
		temps(101, 130);
		chk("duty_2", 8'hFF, duty_2);
		chk("full", 3'b111, full);
		chk("crit_n", 1'b0, crit_n);
		chk("irq", 1'b0, irq);
		wr(IDX_IRQ_MASK, 32'h1);
		repeat (3) @(posedge clk);
		chk("irq", 1'b1, irq);
		temps(97, 130);
		chk("duty_1", 8'hFF, duty_1);
		temps(80, 80);
		chk("duty_0", 8'h00, duty_0);
		chk("irq", 1'b1, irq);
		xfer(IDX_STATUS, 1'b0, 32'h0);
		chk("status", 32'h1, q & 32'h1);
		repeat (3) @(posedge clk);
		chk("irq", 1'b0, irq);
		wr(IDX_OFS_R1, 32'h08);
		temps(89, 80);
		chk("duty_0", 8'h80, duty_0);
		wr(IDX_OFS_LOC, 32'hF8);
		temps(80, 91);
		chk("duty_1", 8'h00, duty_1);
		// below-start select on output 0 keeps minimum duty
		wr(IDX_CONTROL, 32'h0F16);
		temps(80, 80);
		chk("duty_0", 8'h80, duty_0);
		wr(IDX_CONTROL, 32'h0F07);
		wr(IDX_START_R1, 32'h10);
		rd(IDX_START_R1, 8'h5A);
		wr(IDX_OFS_R1, 32'h00);
		rd(IDX_OFS_R1, 8'h08);
		report_and_stop();
	end
endmodule

/* src/fan_limit_pkg.sv */
/*
 fan limit register bank: offsets, reset values and field positions.
 assumes a classic wishbone slave with 32-bit data, one register per word.
*/
package fan_limit_pkg;
	localparam int          ADDR_W          = 10;
	// printed offsets are register indices; byte address is four times
	localparam logic [7:0]  IDX_MIN_DUTY0   = 8'h64;
	localparam logic [7:0]  IDX_START_R1    = 8'h67;
	localparam logic [7:0]  IDX_START_LOC   = 8'h68;
	localparam logic [7:0]  IDX_START_R2    = 8'h69;
	localparam logic [7:0]  IDX_CRIT_R1     = 8'h6A;
	localparam logic [7:0]  IDX_CRIT_LOC    = 8'h6B;
	localparam logic [7:0]  IDX_CRIT_R2     = 8'h6C;
	localparam logic [7:0]  IDX_HYST_R1LOC  = 8'h6D;
	localparam logic [7:0]  IDX_HYST_R2     = 8'h6E;
	localparam logic [7:0]  IDX_XOR_TEST    = 8'h6F;
	localparam logic [7:0]  IDX_OFS_R1      = 8'h70;
	localparam logic [7:0]  IDX_OFS_LOC     = 8'h71;
	localparam logic [7:0]  IDX_CONTROL     = 8'h80;
	localparam logic [7:0]  IDX_STATUS      = 8'h81;
	localparam logic [7:0]  IDX_IRQ_MASK    = 8'h82;
	localparam logic [7:0]  RST_MIN_DUTY    = 8'h80;
	localparam logic [7:0]  RST_START       = 8'h5A;
	localparam logic [7:0]  RST_CRIT        = 8'h64;
	localparam logic [7:0]  RST_HYST_R1LOC  = 8'h44;
	localparam logic [7:0]  RST_HYST_R2     = 8'h40;
	localparam logic [7:0]  RST_ZERO        = 8'h00;
	localparam logic [7:0]  CRIT_DISABLE    = 8'h80;
	localparam logic [7:0]  DUTY_FULL       = 8'hFF;
	localparam logic [7:0]  DUTY_OFF        = 8'h00;
	// control register fields
	localparam int          CTL_LOCK        = 0;
	localparam int          CTL_AUTO        = 1;
	localparam int          CTL_CRIT_OE     = 2;
	localparam int          CTL_BELOW_SEL   = 4;
	localparam int          CTL_SPAN        = 8;
	// status fields: one override bit per channel, one pin-assert bit
	localparam int          ST_CRIT_PIN     = 3;
endpackage

/* src/fan_limit_regs.sv */
/*
 fan control limit register bank with automatic duty control per channel.
 assumes temperature readings in quarter degrees from the same clock domain,
 and a fixed channel-to-output pairing: output i follows channel i.
*/
// Added by the designer: register access over Wishbone.
// Functional notes
// - minimum duty code is a linear fraction, 0x00 off, 0xFF full.
// - above start temperature fan runs minimum duty, rising over the span.
// - any channel above its critical limit forces all outputs full duty.
// - critical limit code 0x80 disables that channel's override.
// - override holds until temperature drops below limit minus hysteresis.
// - critical pin, when enabled, asserts low a quarter degree over limit.
// - each channel holds a 4-bit hysteresis, up to fifteen degrees.
// - below start, fan stays at minimum until start minus hysteresis.
// - one hysteresis per channel serves both fan-off and override release.
// - lock bit makes limit, hysteresis, test and offset registers read-only.
// - test register bit 0 enters xor tree test mode, clear leaves it.
// - remote 1 reading gets signed quarter-degree offset added.
// - local reading gets signed quarter-degree offset added.
// - per-output select picks zero or minimum duty below start-hysteresis.
// - minimum duty registers are read-only in automatic mode.
`timescale 1ns/100ps
module fan_limit_regs
	import fan_limit_pkg::*;
#(
	parameter int NCH = 3
) (
	input  wire logic              clk,
	input  wire logic              resetn,
	input  wire logic [ADDR_W-1:0] wb_adr_i,
	input  wire logic [31:0]       wb_dat_i,
	input  wire logic [3:0]        wb_sel_i,
	input  wire logic              wb_we_i,
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	output logic      [31:0]       wb_dat_o,
	output logic                   wb_ack_o,
	input  wire logic [9:0]        temp_remote1,
	input  wire logic [9:0]        temp_local,
	input  wire logic [9:0]        temp_remote2,
	output logic      [7:0]        duty_0,
	output logic      [7:0]        duty_1,
	output logic      [7:0]        duty_2,
	output logic                   critical_temp_signal_n,
	output logic                   xor_test_enable,
	output logic                   irq
);
	logic [7:0]  min_duty_q [NCH];
	logic [7:0]  start_q    [NCH];
	logic [7:0]  crit_q     [NCH];
	logic [7:0]  hyst_r1loc_q;
	logic [7:0]  hyst_r2_q;
	logic [7:0]  xor_test_q;
	logic [7:0]  ofs_r1_q;
	logic [7:0]  ofs_loc_q;
	logic [15:0] control_q;
	logic [7:0]  status_q;
	logic [7:0]  mask_q;
	logic [NCH-1:0] run_q;
	logic [NCH-1:0] ovr_q;
	logic [7:0]  duty_q [NCH];
	logic        crit_pin_q;
	logic [31:0] rdata_d;
	logic [7:0]  ev_d;

	wire         access = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire [7:0]   idx    = wb_adr_i[ADDR_W-1:2];
	wire         wr0    = access & wb_we_i & wb_sel_i[0];
	wire         wr1    = access & wb_we_i & wb_sel_i[1];
	wire         locked = control_q[CTL_LOCK];
	wire         auto   = control_q[CTL_AUTO];

	// corrected readings, quarter degrees, signed 11 bits
	logic signed [10:0] corr [NCH];
	logic [3:0]          hyst [NCH];
	assign corr[0] = $signed({1'b0, temp_remote1})
		+ {{3{ofs_r1_q[7]}}, ofs_r1_q};
	assign corr[1] = $signed({1'b0, temp_local})
		+ {{3{ofs_loc_q[7]}}, ofs_loc_q};
	assign corr[2] = $signed({1'b0, temp_remote2});
	assign hyst[0] = hyst_r1loc_q[7:4];
	assign hyst[1] = hyst_r1loc_q[3:0];
	assign hyst[2] = hyst_r2_q[7:4];

	// bus ack, one cycle after request, dropped the next
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= access;
		end
	end

	always_comb begin
		rdata_d = 32'h0000_0000;
		case (idx)
			IDX_HYST_R1LOC: rdata_d[7:0] = hyst_r1loc_q;
			IDX_HYST_R2:    rdata_d[7:0] = hyst_r2_q;
			IDX_XOR_TEST:   rdata_d[7:0] = xor_test_q;
			IDX_OFS_R1:     rdata_d[7:0] = ofs_r1_q;
			IDX_OFS_LOC:    rdata_d[7:0] = ofs_loc_q;
			IDX_CONTROL:    rdata_d[15:0] = control_q;
			IDX_STATUS:     rdata_d[7:0] = status_q;
			IDX_IRQ_MASK:   rdata_d[7:0] = mask_q;
			default: begin
				for (int i = 0; i < NCH; i++) begin
					if (idx == IDX_MIN_DUTY0 + 8'(i))
						rdata_d[7:0] = min_duty_q[i];
					if (idx == IDX_START_R1 + 8'(i))
						rdata_d[7:0] = start_q[i];
					if (idx == IDX_CRIT_R1 + 8'(i))
						rdata_d[7:0] = crit_q[i];
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (access && !wb_we_i) begin
			wb_dat_o <= rdata_d;
		end
	end

	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : ch
			wire [7:0] dg = corr[g][9:2];
			wire       neg = corr[g][10];
			wire above_start = !neg && dg > start_q[g];
			// add on the left so a small start cannot wrap below zero
			wire below_off = neg ||
				{1'b0, dg} + {5'h00, hyst[g]} < {1'b0, start_q[g]};
			wire crit_en = crit_q[g] != CRIT_DISABLE;
			wire above_crit = !neg && dg > crit_q[g];
			wire below_rel = neg ||
				{1'b0, dg} + {5'h00, hyst[g]} < {1'b0, crit_q[g]};
			wire [8:0] over = {1'b0, dg} - {1'b0, start_q[g]};
			wire [15:0] ramp = 16'(over) *
				16'(8'hFF - min_duty_q[g]);
			// one span field shared by all channels
			wire [3:0] span = control_q[CTL_SPAN +: 4];
			// saturate on the full-width sum so a big step never wraps
			wire [16:0] dsum = {9'h000, min_duty_q[g]} +
				{1'b0, ramp >> span};

			always_ff @(posedge clk or negedge resetn) begin
				if (!resetn) begin
					min_duty_q[g] <= RST_MIN_DUTY;
				end else if (wr0 && !auto &&
					idx == IDX_MIN_DUTY0 + 8'(g)) begin
					min_duty_q[g] <= wb_dat_i[7:0];
				end
			end

			always_ff @(posedge clk or negedge resetn) begin
				if (!resetn) begin
					start_q[g] <= RST_START;
					crit_q[g]  <= RST_CRIT;
				end else if (wr0 && !locked) begin
					if (idx == IDX_START_R1 + 8'(g))
						start_q[g] <= wb_dat_i[7:0];
					if (idx == IDX_CRIT_R1 + 8'(g))
						crit_q[g] <= wb_dat_i[7:0];
				end
			end

			always_ff @(posedge clk or negedge resetn) begin
				if (!resetn) begin
					run_q[g] <= 1'b0;
				end else if (above_start) begin
					run_q[g] <= 1'b1;
				end else if (below_off) begin
					run_q[g] <= 1'b0;
				end
			end

			always_ff @(posedge clk or negedge resetn) begin
				if (!resetn) begin
					ovr_q[g] <= 1'b0;
				end else if (!crit_en) begin
					ovr_q[g] <= 1'b0;
				end else if (above_crit) begin
					ovr_q[g] <= 1'b1;
				end else if (below_rel) begin
					ovr_q[g] <= 1'b0;
				end
			end

			always_ff @(posedge clk or negedge resetn) begin
				if (!resetn) begin
					duty_q[g] <= DUTY_OFF;
				end else if (|ovr_q) begin
					duty_q[g] <= DUTY_FULL;
				end else if (!auto) begin
					duty_q[g] <= min_duty_q[g];
				end else if (above_start) begin
					duty_q[g] <= (dsum > 17'h000FF) ? DUTY_FULL :
						dsum[7:0];
				end else if (run_q[g]) begin
					duty_q[g] <= min_duty_q[g];
				end else begin
					duty_q[g] <= control_q[CTL_BELOW_SEL+g] ?
						min_duty_q[g] : DUTY_OFF;
				end
			end
		end
	endgenerate

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			hyst_r1loc_q <= RST_HYST_R1LOC;
			hyst_r2_q    <= RST_HYST_R2;
			xor_test_q   <= RST_ZERO;
			ofs_r1_q     <= RST_ZERO;
			ofs_loc_q    <= RST_ZERO;
		end else if (wr0 && !locked) begin
			case (idx)
				IDX_HYST_R1LOC: hyst_r1loc_q <= wb_dat_i[7:0];
				IDX_HYST_R2:    hyst_r2_q    <= wb_dat_i[7:0];
				IDX_XOR_TEST:   xor_test_q   <= wb_dat_i[7:0];
				IDX_OFS_R1:     ofs_r1_q     <= wb_dat_i[7:0];
				IDX_OFS_LOC:    ofs_loc_q    <= wb_dat_i[7:0];
				default: ;
			endcase
		end
	end

	// lock is sticky until reset, like a real lock should be
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			control_q <= 16'h0000;
		end else if (idx == IDX_CONTROL && !locked) begin
			if (wr0)
				control_q[7:0] <= wb_dat_i[7:0];
			if (wr1)
				control_q[15:8] <= wb_dat_i[15:8];
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			mask_q <= 8'h00;
		end else if (wr0 && idx == IDX_IRQ_MASK) begin
			mask_q <= wb_dat_i[7:0];
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			crit_pin_q <= 1'b0;
		end else begin
			crit_pin_q <= 1'b0;
			for (int i = 0; i < NCH; i++)
				if (crit_q[i] != CRIT_DISABLE &&
					corr[i] > $signed({1'b0, crit_q[i], 2'b00}))
					crit_pin_q <= control_q[CTL_CRIT_OE];
		end
	end

	always_comb begin
		ev_d = 8'h00;
		ev_d[NCH-1:0] = ovr_q;
		ev_d[ST_CRIT_PIN] = crit_pin_q;
	end

	// read clears status, but a same-cycle event still sets
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			status_q <= 8'h00;
		end else begin
			status_q <= ((access && !wb_we_i && idx == IDX_STATUS) ?
				8'h00 : status_q) | ev_d;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(status_q & mask_q);
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			critical_temp_signal_n <= 1'b1;
			xor_test_enable        <= 1'b0;
		end else begin
			critical_temp_signal_n <= ~crit_pin_q;
			xor_test_enable        <= xor_test_q[0];
		end
	end

	assign duty_0 = duty_q[0];
	assign duty_1 = duty_q[1];
	assign duty_2 = duty_q[2];

	property p_fail_safe;
		@(posedge clk) disable iff (!resetn)
		|ovr_q |=> (duty_q[0] == DUTY_FULL && duty_q[2] == DUTY_FULL);
	endproperty
	a_fail_safe: assert property (p_fail_safe)
		else $error("override without full duty");

	property p_disabled;
		@(posedge clk) disable iff (!resetn)
		crit_q[1] == CRIT_DISABLE |=> !ovr_q[1];
	endproperty
	a_disabled: assert property (p_disabled)
		else $error("override active on disabled channel");

	property p_lock;
		@(posedge clk) disable iff (!resetn)
		locked |=> $stable(start_q[0]) && $stable(ofs_r1_q)
			&& $stable(hyst_r1loc_q);
	endproperty
	a_lock: assert property (p_lock)
		else $error("locked register changed");

	property p_min_auto;
		@(posedge clk) disable iff (!resetn)
		auto && $past(auto) |-> $stable(min_duty_q[0]);
	endproperty
	a_min_auto: assert property (p_min_auto)
		else $error("minimum duty changed in auto");

	property p_xor;
		@(posedge clk) disable iff (!resetn)
		##1 xor_test_enable == $past(xor_test_q[0]);
	endproperty
	a_xor: assert property (p_xor)
		else $error("test enable out of step");

	property p_ack;
		@(posedge clk) disable iff (!resetn)
		access |=> wb_ack_o ##1 !wb_ack_o;
	endproperty
	a_ack: assert property (p_ack)
		else $error("ack not a single cycle");

	property p_manual;
		@(posedge clk) disable iff (!resetn)
		!auto && !(|ovr_q) |=> duty_q[1] == $past(min_duty_q[1]);
	endproperty
	a_manual: assert property (p_manual)
		else $error("manual duty not minimum");

	property p_irq;
		@(posedge clk) disable iff (!resetn)
		(status_q & mask_q) != 8'h00 |=> irq;
	endproperty
	a_irq: assert property (p_irq)
		else $error("irq missing");
endmodule
